// >>> shared/dbu_pkg.sv
// Constants and register layout shared by the debug breakpoint unit files
package dbu_pkg;

  localparam int          NBP          = 4;
  localparam int          STEP_BIT     = 8;

  // Register byte offsets on the register bus
  localparam logic [7:0]  OFF_ADDR0    = 8'h00;
  localparam logic [7:0]  OFF_ADDR1    = 8'h04;
  localparam logic [7:0]  OFF_ADDR2    = 8'h08;
  localparam logic [7:0]  OFF_ADDR3    = 8'h0C;
  localparam logic [7:0]  OFF_STATUS   = 8'h18;
  localparam logic [7:0]  OFF_CTRL     = 8'h1C;

  // breakpoint_control field positions
  localparam int          CTL_LE_BIT   = 8;
  localparam int          CTL_GE_BIT   = 9;
  localparam int          CTL_GD_BIT   = 13;
  localparam int          CTL_RW_BASE  = 16;
  localparam int          CTL_LEN_BASE = 18;
  localparam int          CTL_FLD_STEP = 4;
  localparam logic [31:0] CTL_LOCAL_MSK = 32'h0000_0155;
  localparam logic [31:0] CTL_WMASK    = 32'hFFFF_23FF;

  // breakpoint_status_reg field positions
  localparam int          STS_GUARD_BIT = 13;
  localparam int          STS_STEP_BIT  = 14;
  localparam logic [31:0] STS_WMASK    = 32'h0000_600F;

  // Values after reset
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] STS_RESET    = 32'h0000_0000;

  // access_type_code and match_size_code encodings
  localparam logic [1:0]  RW_EXEC      = 2'h0;
  localparam logic [1:0]  RW_WR        = 2'h1;
  localparam logic [1:0]  RW_RDWR      = 2'h3;
  localparam logic [1:0]  LEN_2        = 2'h1;
  localparam logic [1:0]  LEN_4        = 2'h3;

endpackage

// >>> rtl/dbu_match.sv
// Address comparator for one linear-address breakpoint
`timescale 1ns/1ps
module dbu_match
  import dbu_pkg::*;
(
  input  wire logic [31:0] bp_addr,
  input  wire logic [1:0]  size_code,
  input  wire logic [1:0]  type_code,
  input  wire logic        exec_valid,
  input  wire logic [31:0] exec_addr,
  input  wire logic        data_valid,
  input  wire logic [31:0] data_addr,
  input  wire logic [1:0]  data_len,
  input  wire logic        data_write,
  output logic             exec_hit,
  output logic             data_hit
);

  logic [32:0] fld_lo;
  logic [32:0] fld_hi;
  logic [32:0] acc_lo;
  logic [32:0] acc_hi;
  logic        type_ok;

  always_comb begin
    fld_lo = {1'b0, bp_addr};
    fld_hi = fld_lo;
    // Undefined size code 10 falls back to a single byte
    unique case (size_code)
      LEN_2: begin
        fld_lo[0] = 1'b0;
        fld_hi    = fld_lo + 33'h0_0000_0001;
      end
      LEN_4: begin
        fld_lo[1:0] = 2'b00;
        fld_hi      = fld_lo + 33'h0_0000_0003;
      end
      default: fld_hi = fld_lo;
    endcase
    acc_lo = {1'b0, data_addr};
    acc_hi = acc_lo + 33'(data_len);
  end

  // Code 10 never matches, so a misprogrammed breakpoint stays silent
  assign type_ok  = ((type_code == RW_WR) && data_write) || (type_code == RW_RDWR);
  // Any byte overlap counts, whole or partial
  assign data_hit = data_valid && type_ok && (acc_lo <= fld_hi) && (fld_lo <= acc_hi);
  // Only the first byte of the instruction matches
  assign exec_hit = exec_valid && (type_code == RW_EXEC) && (exec_addr == bp_addr);

endmodule // dbu_match

// >>> rtl/dbu_step.sv
// Single-step trap detector
`timescale 1ns/1ps
module dbu_step
  import dbu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic instr_done,
  input  wire logic step_flag,
  output logic      step_trap
);

  logic armed_ff;

  // Flag as seen at the previous completion; the setting instruction is skipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b0;
    end else if (instr_done) begin
      armed_ff <= step_flag;
    end
  end

  assign step_trap = instr_done && armed_ff && step_flag;

endmodule // dbu_step

// >>> rtl/dbu_top.sv
// Debug breakpoint unit: breakpoints, single step, debug register guard
//
// Functional notes
// - Trap on vector 1 when step flag set
// - Step trap after instruction following the setter
// - Trap return pointer addresses next instruction
// - All breakpoints disabled after reset
// - Four 32-bit linear addresses compared continuously
// - Size code selects byte, word, doubleword field
// - Type code: execute, write, read-or-write
// - Execute breakpoint faults; data breakpoint traps
// - Any byte overlap triggers data breakpoint
// - Execute match only at instruction start
// - Register access only real mode or level 0
// - Guard bit makes register access fault
// - Guard bit cleared on handler entry
// - Data breakpoints always reported exactly
// - Task switch clears local exact-match bit and local enables
// - Local or global enable arms breakpoint
// - Task switch clears local enables and local exact-match bit only
// - Status flags set by hardware, cleared only by software write
// - Enabled hit sets all matching flags
// - Guard fault sets guard status flag
// - Step trap sets step status flag
`timescale 1ns/1ps
module dbu_top
  import dbu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_done,
  input  wire logic [31:0] processor_flags_register,
  input  wire logic [31:0] next_ptr,
  input  wire logic        exec_valid,
  input  wire logic [31:0] exec_addr,
  input  wire logic        data_valid,
  input  wire logic [31:0] data_addr,
  input  wire logic [1:0]  data_len,
  input  wire logic        data_write,
  input  wire logic        task_switch,
  input  wire logic        dreg_req,
  input  wire logic        dreg_write,
  input  wire logic [2:0]  dreg_sel,
  input  wire logic [31:0] dreg_wdata,
  input  wire logic        real_mode,
  input  wire logic [1:0]  priv_level,
  output logic             exc1,
  output logic             exc1_fault,
  output logic [31:0]      return_pointer,
  output logic             dreg_done,
  output logic             dreg_denied,
  output logic [31:0]      dreg_rdata
);

  logic [31:0]    bp_addr_ff [NBP];
  logic [31:0]    ctrl_ff;
  logic [31:0]    status_ff;
  logic [NBP-1:0] pend_ff;
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;
  logic           exc1_ff;
  logic           exc1_fault_ff;
  logic [31:0]    ret_ptr_ff;
  logic           dreg_done_ff;
  logic           dreg_denied_ff;
  logic [31:0]    dreg_rdata_ff;

  logic [NBP-1:0] armed;
  logic [NBP-1:0] exec_hit;
  logic [NBP-1:0] data_hit;
  logic           step_trap;
  logic           guard_on;
  logic           dreg_priv_ok;
  logic           guard_fault;
  logic           exec_fault;
  logic           trap_now;
  logic           enter_handler;
  logic           apb_take;
  logic           apb_wr;
  logic           core_ok;
  logic           core_wr;
  logic           wr_en;
  logic [7:0]     wr_off;
  logic [31:0]    wr_data;
  logic [7:0]     core_off;
  logic [32:0]    apb_rd;
  logic [32:0]    core_rd;
  logic [NBP-1:0] nxt_flags;
  logic [31:0]    nxt_ctrl;
  logic [31:0]    nxt_status;

  // Read decode shared by the bus and the core; bit 32 marks a mapped offset
  function automatic logic [32:0] rd_mux(input logic [7:0] off,
                                         input logic [31:0] a0,
                                         input logic [31:0] a1,
                                         input logic [31:0] a2,
                                         input logic [31:0] a3,
                                         input logic [31:0] sts,
                                         input logic [31:0] ctl);
    logic [32:0] r;
    r = 33'h0_0000_0000;
    unique case (off)
      OFF_ADDR0:  r = {1'b1, a0};
      OFF_ADDR1:  r = {1'b1, a1};
      OFF_ADDR2:  r = {1'b1, a2};
      OFF_ADDR3:  r = {1'b1, a3};
      OFF_STATUS: r = {1'b1, sts};
      OFF_CTRL:   r = {1'b1, ctl};
      default:    r = 33'h0_0000_0000;
    endcase
    return r;
  endfunction

  // One comparator per breakpoint, all running every cycle
  genvar gi;
  generate
    for (gi = 0; gi < NBP; gi++) begin : g_bp
      assign armed[gi] = ctrl_ff[2*gi] | ctrl_ff[2*gi+1];
      dbu_match u_match (
        .bp_addr    (bp_addr_ff[gi]),
        .size_code  (ctrl_ff[CTL_LEN_BASE + CTL_FLD_STEP*gi +: 2]),
        .type_code  (ctrl_ff[CTL_RW_BASE + CTL_FLD_STEP*gi +: 2]),
        .exec_valid (exec_valid),
        .exec_addr  (exec_addr),
        .data_valid (data_valid),
        .data_addr  (data_addr),
        .data_len   (data_len),
        .data_write (data_write),
        .exec_hit   (exec_hit[gi]),
        .data_hit   (data_hit[gi])
      );
    end
  endgenerate

  dbu_step u_step (
    .pclk       (pclk),
    .presetn    (presetn),
    .instr_done (instr_done),
    .step_flag  (processor_flags_register[STEP_BIT]),
    .step_trap  (step_trap)
  );

  // Core-side debug register access checks
  assign guard_on     = ctrl_ff[CTL_GD_BIT];
  assign dreg_priv_ok = real_mode || (priv_level == 2'b00);
  assign guard_fault  = dreg_req && guard_on;
  assign core_ok      = dreg_req && !guard_on && dreg_priv_ok;
  assign core_off     = {3'b000, dreg_sel, 2'b00};

  // Exception sources
  assign exec_fault = exec_valid && |(exec_hit & armed);
  // Data hits wait for the instruction boundary so the trap is exact
  assign trap_now   = instr_done && (step_trap || |pend_ff || |(data_hit & armed));
  // Every cause folds into a single entry
  assign enter_handler = trap_now || exec_fault || guard_fault;

  // Register bus: one wait state, write commits on the completing edge
  assign apb_take = psel && penable && !pready_ff;
  assign apb_wr   = psel && penable && pready_ff && pwrite;
  assign core_wr  = core_ok && dreg_write;
  assign apb_rd   = rd_mux(paddr, bp_addr_ff[0], bp_addr_ff[1], bp_addr_ff[2],
                           bp_addr_ff[3], status_ff, ctrl_ff);
  assign core_rd  = rd_mux(core_off, bp_addr_ff[0], bp_addr_ff[1], bp_addr_ff[2],
                           bp_addr_ff[3], status_ff, ctrl_ff);

  // Bus write wins a same-cycle collision with a core write
  always_comb begin
    wr_en   = apb_wr || core_wr;
    wr_off  = apb_wr ? paddr : core_off;
    wr_data = apb_wr ? pwdata : dreg_wdata;
  end

  // Ready follows every access phase after exactly one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= apb_take;
    end
  end

  // Read data and error stand only in the ready cycle, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      if (apb_take) begin
        prdata_ff  <= pwrite ? 32'h0000_0000 : apb_rd[31:0];
        pslverr_ff <= !apb_rd[32];
      end else begin
        prdata_ff  <= 32'h0000_0000;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Breakpoint address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBP; i++) begin
        bp_addr_ff[i] <= ADDR_RESET;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NBP; i++) begin
        if (wr_off == OFF_ADDR0 + 8'(4*i)) begin
          bp_addr_ff[i] <= wr_data;
        end
      end
    end
  end

  // Control: task switch and handler entry act after any software write
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_en && (wr_off == OFF_CTRL)) begin
      nxt_ctrl = wr_data & CTL_WMASK;
    end
    if (task_switch) begin
      nxt_ctrl = nxt_ctrl & ~CTL_LOCAL_MSK;
      nxt_ctrl[CTL_LE_BIT] = 1'b0;
    end
    if (enter_handler) begin
      nxt_ctrl[CTL_GD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Unarmed matches are recorded only when some armed match fires with them
  always_comb begin
    nxt_flags = '0;
    if (|(exec_hit & armed) || |(data_hit & armed)) begin
      nxt_flags = exec_hit | data_hit;
    end
  end

  // Status: hardware sets win over a software write in the same cycle
  always_comb begin
    nxt_status = status_ff;
    if (wr_en && (wr_off == OFF_STATUS)) begin
      nxt_status = wr_data & STS_WMASK;
    end
    nxt_status[NBP-1:0] = nxt_status[NBP-1:0] | nxt_flags;
    if (guard_fault) begin
      nxt_status[STS_GUARD_BIT] = 1'b1;
    end
    if (step_trap) begin
      nxt_status[STS_STEP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= STS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Data hits raised mid-instruction wait for the boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= '0;
    end else if (instr_done) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= pend_ff | (data_hit & armed);
    end
  end

  // Exception request to the sequencer; a boundary trap outranks a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc1_ff       <= 1'b0;
      exc1_fault_ff <= 1'b0;
    end else begin
      exc1_ff       <= enter_handler;
      exc1_fault_ff <= !trap_now && (exec_fault || guard_fault);
    end
  end

  // Return pointer holds between entries so the sequencer may read it late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_ptr_ff <= 32'h0000_0000;
    end else begin
      if (trap_now) begin
        ret_ptr_ff <= next_ptr;
      end else if (exec_fault || guard_fault) begin
        ret_ptr_ff <= exec_addr;
      end
    end
  end

  // Core debug register answers, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreg_done_ff   <= 1'b0;
      dreg_denied_ff <= 1'b0;
    end else begin
      dreg_done_ff   <= core_ok;
      dreg_denied_ff <= dreg_req && !guard_on && !dreg_priv_ok;
    end
  end

  // Read data holds, so a slow core may pick it up after the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreg_rdata_ff <= 32'h0000_0000;
    end else begin
      if (core_ok && !dreg_write) begin
        dreg_rdata_ff <= core_rd[31:0];
      end
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign exc1           = exc1_ff;
  assign exc1_fault     = exc1_fault_ff;
  assign return_pointer = ret_ptr_ff;
  assign dreg_done      = dreg_done_ff;
  assign dreg_denied    = dreg_denied_ff;
  assign dreg_rdata     = dreg_rdata_ff;

endmodule // dbu_top

// >>> test/dbu_props.sv
// Port assertions for the debug breakpoint unit
`timescale 1ns/1ps
module dbu_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        instr_done,
  input wire logic [31:0] next_ptr,
  input wire logic        exec_valid,
  input wire logic [31:0] exec_addr,
  input wire logic        dreg_req,
  input wire logic        real_mode,
  input wire logic [1:0]  priv_level,
  input wire logic        exc1,
  input wire logic        exc1_fault,
  input wire logic [31:0] return_pointer,
  input wire logic        dreg_done,
  input wire logic        dreg_denied
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase got no ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdz; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside ready cycle");
  property p_rst; $rose(presetn) |-> !exc1 && !dreg_done; endproperty
  a_rst: assert property (p_rst) else $error("activity right after reset");
  property p_trap; exc1 && !exc1_fault |-> $past(instr_done) && return_pointer == $past(next_ptr);
  endproperty
  a_trap: assert property (p_trap) else $error("trap without completion");
  property p_fsrc; exc1 && exc1_fault |-> $past(exec_valid) || $past(dreg_req); endproperty
  a_fsrc: assert property (p_fsrc) else $error("fault without cause");
  property p_fptr; exc1 && exc1_fault |-> return_pointer == $past(exec_addr); endproperty
  a_fptr: assert property (p_fptr) else $error("fault pointer wrong");
  // Guard fault outranks the privilege check, so exc1 is legal on both paths
  property p_deny; dreg_req && !real_mode && priv_level != 2'h0 |=> dreg_denied || exc1; endproperty
  a_deny: assert property (p_deny) else $error("privileged access not refused");
  property p_allow; dreg_req && (real_mode || priv_level == 2'h0) |=> dreg_done || exc1; endproperty
  a_allow: assert property (p_allow) else $error("allowed access not done");
  property p_one; !(dreg_done && dreg_denied); endproperty
  a_one: assert property (p_one) else $error("done and denied together");
  c_fault: cover property (exc1 && exc1_fault);
  c_trap: cover property (exc1 && !exc1_fault);
  c_deny: cover property (dreg_denied);
endmodule // dbu_props

bind dbu_top dbu_props i_dbu_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .prdata, .instr_done, .next_ptr, .exec_valid, .exec_addr, .dreg_req, .real_mode,
  .priv_level, .exc1, .exc1_fault, .return_pointer, .dreg_done, .dreg_denied);

// >>> test/dbu_core.sv
// Execution unit model driving the core side of the unit
`timescale 1ns/1ps
module dbu_core (
  input  wire logic   pclk,
  output logic        instr_done,
  output logic [31:0] processor_flags_register,
  output logic [31:0] next_ptr,
  output logic        exec_valid,
  output logic [31:0] exec_addr,
  output logic        data_valid,
  output logic [31:0] data_addr,
  output logic [1:0]  data_len,
  output logic        data_write,
  output logic        task_switch,
  output logic        dreg_req,
  output logic        dreg_write,
  output logic [2:0]  dreg_sel,
  output logic [31:0] dreg_wdata,
  output logic        real_mode,
  output logic [1:0]  priv_level
);
  initial begin
    {instr_done, exec_valid, data_valid, data_write, task_switch} = '0;
    {dreg_req, dreg_write, real_mode, data_len, dreg_sel, priv_level} = '0;
    {processor_flags_register, next_ptr, exec_addr, data_addr, dreg_wdata} = '0;
  end
  // One request kind per call, so completion never shares a cycle with a fault
  task automatic instr(input logic [31:0] flags, input logic [31:0] ptr);
    @(posedge pclk);
    instr_done <= 1'b1;
    processor_flags_register <= flags;
    next_ptr <= ptr;
    @(posedge pclk);
    instr_done <= 1'b0;
    next_ptr <= ~ptr;
    #1;
  endtask
  task automatic exec(input logic [31:0] a);
    @(posedge pclk);
    exec_valid <= 1'b1;
    exec_addr <= a;
    @(posedge pclk);
    exec_valid <= 1'b0;
    #1;
  endtask
  task automatic data(input logic [31:0] a, input logic [1:0] len, input logic w);
    @(posedge pclk);
    data_valid <= 1'b1;
    data_addr <= a;
    data_len <= len;
    data_write <= w;
    @(posedge pclk);
    data_valid <= 1'b0;
    data_addr <= ~a;
    #1;
  endtask
  task automatic tsw();
    @(posedge pclk);
    task_switch <= 1'b1;
    @(posedge pclk);
    task_switch <= 1'b0;
    #1;
  endtask
  // The fault pointer comes from exec_addr, so it is held across the access
  task automatic dreg(input logic rm, input logic [1:0] pl, input logic [31:0] ea);
    @(posedge pclk);
    dreg_req <= 1'b1;
    real_mode <= rm;
    priv_level <= pl;
    exec_addr <= ea;
    @(posedge pclk);
    dreg_req <= 1'b0;
    #1;
  endtask
  // Allowed core access at level 0; exec_addr is left as it stands
  task automatic dreg_rw(input logic w, input logic [2:0] s, input logic [31:0] d);
    @(posedge pclk);
    dreg_req <= 1'b1;
    dreg_write <= w;
    dreg_sel <= s;
    dreg_wdata <= d;
    real_mode <= 1'b0;
    priv_level <= 2'd0;
    @(posedge pclk);
    dreg_req <= 1'b0;
    dreg_write <= 1'b0;
    #1;
  endtask
endmodule // dbu_core

// >>> test/test_debug_breakpoint_unit.sv
// Testbench for the debug breakpoint unit
`timescale 1ns/1ps
module test_debug_breakpoint_unit
  import dbu_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, processor_flags_register, next_ptr, exec_addr;
  logic [31:0] data_addr, dreg_wdata, return_pointer, dreg_rdata;
  logic        instr_done, exec_valid, data_valid, data_write, task_switch, dreg_req;
  logic        dreg_write, real_mode, exc1, exc1_fault, dreg_done, dreg_denied;
  logic [1:0]  data_len, priv_level;
  logic [2:0]  dreg_sel;
  logic [7:0]  offs [6] = '{OFF_ADDR0, OFF_ADDR1, OFF_ADDR2, OFF_ADDR3, OFF_STATUS, OFF_CTRL};
  int          fail_count, comparisons;

  dbu_top i_dbu_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_done, .processor_flags_register, .next_ptr, .exec_valid,
    .exec_addr, .data_valid, .data_addr, .data_len, .data_write, .task_switch, .dreg_req,
    .dreg_write, .dreg_sel, .dreg_wdata, .real_mode, .priv_level, .exc1, .exc1_fault,
    .return_pointer, .dreg_done, .dreg_denied, .dreg_rdata);
  dbu_core i_dbu_core (.pclk, .instr_done, .processor_flags_register, .next_ptr,
    .exec_valid, .exec_addr, .data_valid, .data_addr, .data_len, .data_write,
    .task_switch, .dreg_req, .dreg_write, .dreg_sel, .dreg_wdata, .real_mode, .priv_level);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0000_0000, 32'h0000_0001);
      finish_test();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  task automatic exc(input logic [1:0] exp);
    chk({30'h0, exc1, exc1_fault}, {30'h0, exp});
  endtask
  task automatic dtest(input logic [31:0] a, input logic [1:0] len, input logic w, hit);
    i_dbu_core.data(a, len, w);
    i_dbu_core.instr(32'h0000_0000, 32'h0000_3000);
    exc({hit, 1'b0});
    if (hit) chk(return_pointer, 32'h0000_3000);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fail_count, comparisons} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b1, OFF_CTRL, 32'hFFFF_FFFF);
    rd(OFF_CTRL, CTL_WMASK);
    apb(1'b1, OFF_ADDR0, 32'h0000_1000);
    apb(1'b1, OFF_ADDR1, 32'h0000_1000);
    rd(OFF_ADDR1, 32'h0000_1000);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    i_dbu_core.exec(32'h0000_1001);
    exc(2'b00);
    i_dbu_core.exec(32'h0000_1000);
    exc(2'b11);
    chk(return_pointer, 32'h0000_1000);
    rd(OFF_STATUS, 32'h0000_0003);
    apb(1'b1, OFF_STATUS, 32'h0000_0000);
    // Slot 2: doubleword write breakpoint covering 2004..2007
    apb(1'b1, OFF_ADDR2, 32'h0000_2005);
    apb(1'b1, OFF_CTRL, 32'h0D00_0020);
    dtest(32'h0000_2004, 2'd3, 1'b0, 1'b0);
    dtest(32'h0000_2002, 2'd1, 1'b1, 1'b0);
    dtest(32'h0000_2003, 2'd1, 1'b1, 1'b1);
    dtest(32'h0000_2007, 2'd0, 1'b1, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0321);
    i_dbu_core.tsw();
    rd(OFF_CTRL, 32'h0000_0220);
    apb(1'b1, OFF_STATUS, 32'h0000_0000);
    i_dbu_core.instr(32'h0000_0100, 32'h0000_4000);
    exc(2'b00);
    i_dbu_core.instr(32'h0000_0100, 32'h0000_4004);
    exc(2'b10);
    chk(return_pointer, 32'h0000_4004);
    rd(OFF_STATUS, 32'h0000_4000);
    i_dbu_core.dreg(1'b0, 2'd3, 32'h0000_5000);
    chk({30'h0, dreg_done, dreg_denied}, 32'h0000_0001);
    i_dbu_core.dreg(1'b0, 2'd0, 32'h0000_5000);
    chk({30'h0, dreg_done, dreg_denied}, 32'h0000_0002);
    chk(dreg_rdata, 32'h0000_1000);
    i_dbu_core.dreg(1'b1, 2'd3, 32'h0000_5000);
    chk({30'h0, dreg_done, dreg_denied}, 32'h0000_0002);
    apb(1'b1, OFF_STATUS, 32'h0000_0000);
    apb(1'b1, OFF_CTRL, 32'h0000_2000);
    i_dbu_core.dreg(1'b1, 2'd0, 32'h0000_5000);
    exc(2'b11);
    chk(return_pointer, 32'h0000_5000);
    rd(OFF_STATUS, 32'h0000_2000);
    rd(OFF_CTRL, 32'h0000_0000);
    i_dbu_core.dreg_rw(1'b1, 3'd2, 32'h0000_6000);
    chk({30'h0, dreg_done, dreg_denied}, 32'h0000_0002);
    rd(OFF_ADDR2, 32'h0000_6000);
    i_dbu_core.dreg_rw(1'b0, 3'd6, 32'h0000_0000);
    chk(dreg_rdata, 32'h0000_2000);
    // Slot 3: word read-or-write breakpoint covering 7002..7003
    apb(1'b1, OFF_ADDR3, 32'h0000_7003);
    apb(1'b1, OFF_CTRL, 32'h7000_0040);
    dtest(32'h0000_7002, 2'd0, 1'b0, 1'b1);
    dtest(32'h0000_7004, 2'd0, 1'b1, 1'b0);
    apb(1'b1, OFF_STATUS, 32'h0000_0000);
    i_dbu_core.instr(32'h0000_0100, 32'h0000_7100);
    exc(2'b00);
    i_dbu_core.data(32'h0000_7003, 2'd0, 1'b0);
    i_dbu_core.instr(32'h0000_0100, 32'h0000_7200);
    exc(2'b10);
    chk(return_pointer, 32'h0000_7200);
    rd(OFF_STATUS, 32'h0000_4008);
    finish_test();
  end
endmodule // test_debug_breakpoint_unit
